// ===== pkg/down_counter_pkg.sv
// Constants and carrier types for the 8-bit presettable down counter.
// Assumes one system clock; pin levels arrive unsynchronised.

package down_counter_pkg;

  // ==========================================================
  // Counter
  // ==========================================================
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] COUNT_RESET = 8'hff;

  // ==========================================================
  // Register map (byte offsets)
  // ==========================================================
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MASK = 4'h4;
  localparam logic [3:0] OFS_COUNT = 4'h8;
  localparam logic [3:0] OFS_PINS = 4'hc;

  // Event bit positions in status and mask
  localparam int EVT_W = 5;
  localparam int EVT_TERMINAL = 0;
  localparam int EVT_WRAP = 1;
  localparam int EVT_SYNC_LOAD = 2;
  localparam int EVT_ASYNC_LOAD = 3;
  localparam int EVT_CLEAR = 4;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [4:0] MASK_RESET = 5'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ==========================================================
  // Carrier types
  // ==========================================================
  typedef struct packed {
    logic count_clock;
    logic clear_to_max_n;
    logic async_load_n;
    logic sync_load_n;
    logic count_enable_n;
    logic [7:0] preset;
  } pins_type;

  localparam pins_type PINS_IDLE = 13'h0f00;

  typedef struct packed {
    pins_type stage1;
    pins_type stage2;
  } sync_state_type;

  typedef struct packed {
    logic clock_prev;
    logic [7:0] count;
    logic [4:0] status;
    logic [4:0] mask;
    logic ack;
    logic [31:0] rdata;
  } core_state_type;

  localparam core_state_type CORE_RESET = '{
    clock_prev: 1'b0, count: COUNT_RESET, status: STATUS_RESET,
    mask: MASK_RESET, ack: 1'b0, rdata: RDATA_RESET};

endpackage

// ===== rtl/down_counter.sv
// 8-bit presettable down counter with Avalon-MM status registers.
// Assumes pins are asynchronous and are synchronised here; the
// count clock pin is sampled by clk_sys_i and must be slower than it.
//
// Contract
// [RULE1] Each count clock rising edge lowers the count by one in normal use.
// [RULE2] Count enable high holds the count unless a load or clear acts.
// [RULE3] Terminal count low when count is zero and enable low.
// [RULE4] Sync load low loads the preset on the next clock edge.
// [RULE5] Async load low forces the preset at once, without a clock edge.
// [RULE6] Clear low sets the count to 255 and overrides everything.
// [RULE7] From zero with controls inactive, the next edge wraps to 255.
// [RULE8] Preset bits form one word, bit seven most significant.
// [RULE9] Priority: clear, async load, sync load, then count enable.
// [RULE10] Stages cascade via terminal count into next count enable.
// [RULE11] Terminal count is a plain decode, with no register stage.
`timescale 1ns/1ps
`default_nettype none

module down_counter (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Counter pins
  input wire logic count_clock_i,
  input wire logic clear_to_max_n_i,
  input wire logic async_load_n_i,
  input wire logic sync_load_n_i,
  input wire logic count_enable_n_i,
  input wire logic [7:0] preset_word_i,
  output logic terminal_count_n_o,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o
);
  import down_counter_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic is_zero(input logic [7:0] value);
    is_zero = (value == COUNT_ZERO);
  endfunction

  function automatic logic [31:0] widen_evt(input logic [4:0] bits);
    widen_evt = {27'h0000000, bits};
  endfunction

  // ==========================================================
  // Pin synchronisation
  // ==========================================================
  pins_type pins_raw;
  pins_type pins;

  always_comb begin
    pins_raw.count_clock = count_clock_i;
    pins_raw.clear_to_max_n = clear_to_max_n_i;
    pins_raw.async_load_n = async_load_n_i;
    pins_raw.sync_load_n = sync_load_n_i;
    pins_raw.count_enable_n = count_enable_n_i;
    // [RULE8] Preset bit order
    pins_raw.preset = preset_word_i;
  end

  down_counter_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .pins_i(pins_raw),
    .pins_o(pins)
  );

  // ==========================================================
  // State
  // ==========================================================
  core_state_type st_ff;
  core_state_type nxt_st;

  logic clock_rise;
  logic bus_req;
  logic bus_take;
  logic bus_done;
  logic [4:0] events;
  logic [4:0] read_clear;
  logic [31:0] read_mux;

  assign clock_rise = pins.count_clock & ~st_ff.clock_prev;
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_take = bus_req & ~st_ff.ack;
  assign bus_done = bus_req & st_ff.ack;

  // ==========================================================
  // Read data selection
  // ==========================================================
  always_comb begin
    case (avs_address_i)
      OFS_STATUS: read_mux = widen_evt(st_ff.status);
      OFS_MASK: read_mux = widen_evt(st_ff.mask);
      OFS_COUNT: read_mux = {24'h000000, st_ff.count};
      OFS_PINS: read_mux = {19'h00000, pins};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    nxt_st = st_ff;
    events = 5'h00;
    read_clear = 5'h00;
    nxt_st.clock_prev = pins.count_clock;

    // [RULE9] Control priority chain
    if (!pins.clear_to_max_n) begin
      // [RULE6] Clear to maximum
      nxt_st.count = COUNT_MAX;
      events[EVT_CLEAR] = 1'b1;
    end else if (!pins.async_load_n) begin
      // [RULE5] Level load, no clock needed
      nxt_st.count = pins.preset;
      events[EVT_ASYNC_LOAD] = 1'b1;
    end else if (clock_rise) begin
      if (!pins.sync_load_n) begin
        // [RULE4] Load on clock edge
        nxt_st.count = pins.preset;
        events[EVT_SYNC_LOAD] = 1'b1;
      end else if (!pins.count_enable_n) begin
        // [RULE1] Decrement by one
        nxt_st.count = st_ff.count - COUNT_ONE;
        // [RULE7] Zero wraps to maximum
        events[EVT_WRAP] = is_zero(st_ff.count);
      end else begin
        // [RULE2] Hold while inhibited
        nxt_st.count = st_ff.count;
      end
    end

    // Terminal count entered
    if (!terminal_count_n_o && !is_zero(nxt_st.count)) begin
      events[EVT_TERMINAL] = 1'b0;
    end
    if (is_zero(nxt_st.count) && !is_zero(st_ff.count)) begin
      events[EVT_TERMINAL] = 1'b1;
    end

    // Bus: one wait cycle, then complete
    nxt_st.ack = bus_take;
    if (bus_take) begin
      nxt_st.rdata = avs_read_i ? read_mux : RDATA_RESET;
    end
    if (bus_done && avs_write_i && avs_byteenable_i[0]
        && avs_address_i == OFS_MASK) begin
      nxt_st.mask = avs_writedata_i[4:0];
    end
    // Clear only bits that were returned, so none is lost
    if (bus_done && avs_read_i && avs_address_i == OFS_STATUS) begin
      read_clear = st_ff.rdata[4:0];
    end
    // Set wins over clear
    nxt_st.status = (st_ff.status & ~read_clear) | events;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_ff <= CORE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // [RULE11] Decode without register stage
  // [RULE3] Low at zero with enable low
  // [RULE10] Feeds next stage enable
  assign terminal_count_n_o = ~(is_zero(st_ff.count) & ~pins.count_enable_n);
  assign avs_waitrequest_o = bus_take;
  assign avs_readdata_o = st_ff.rdata;
  assign irq_o = |(st_ff.status & st_ff.mask);

  // ==========================================================
  // Assertions
  // ==========================================================
  logic ctl_idle;
  assign ctl_idle = pins.clear_to_max_n & pins.async_load_n & pins.sync_load_n;

  // [RULE1] Step down check
  a_count_step: // [RULE1]
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clock_rise && ctl_idle && !pins.count_enable_n
    |=> st_ff.count == $past(st_ff.count) - COUNT_ONE)
  else $error("count did not step down by one");

  // [RULE2] Hold check
  a_hold_inhibit: // [RULE2]
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ctl_idle && pins.count_enable_n |=> $stable(st_ff.count))
  else $error("count changed while inhibited");

  // [RULE3] Output decode check
  a_tc_decode: // [RULE3]
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !terminal_count_n_o == (st_ff.count == COUNT_ZERO && !pins.count_enable_n))
  else $error("terminal count wrong for count and enable");

  // [RULE11] One period then release
  a_tc_release: // [RULE11]
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !terminal_count_n_o && clock_rise && ctl_idle
    |=> terminal_count_n_o && st_ff.count == COUNT_MAX)
  else $error("terminal count held past one count period");

  // [RULE4] Sync load check
  a_sync_load: // [RULE4]
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clock_rise && pins.clear_to_max_n && pins.async_load_n
    && !pins.sync_load_n |=> st_ff.count == $past(pins.preset))
  else $error("sync load did not capture preset");

  // [RULE5] Async load check
  a_async_load: // [RULE5]
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    pins.clear_to_max_n && !pins.async_load_n
    |=> st_ff.count == $past(pins.preset))
  else $error("async load did not force preset");

  // [RULE6] Clear check
  a_clear_max: // [RULE6]
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !pins.clear_to_max_n |=> st_ff.count == COUNT_MAX)
  else $error("clear did not set maximum");

  // [RULE7] Wrap check
  a_wrap_max: // [RULE7]
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    st_ff.count == COUNT_ZERO && clock_rise && ctl_idle
    && !pins.count_enable_n |=> st_ff.count == COUNT_MAX ##0 st_ff.status[EVT_WRAP])
  else $error("zero did not wrap to maximum");

  // [RULE9] No edge, no load, no change
  a_no_edge_hold: // [RULE9]
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !clock_rise && pins.clear_to_max_n && pins.async_load_n
    |=> $stable(st_ff.count))
  else $error("count changed without edge or load");

  a_irq_level:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    irq_o == |(st_ff.status & st_ff.mask))
  else $error("interrupt does not match status and mask");

  a_bus_answer:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    bus_take |=> !avs_waitrequest_o [*1])
  else $error("bus answer not one cycle after request");

endmodule
`default_nettype wire

// ===== rtl/down_counter_sync.sv
// Two-flop synchroniser for all counter pin inputs.
// Assumes every pin is asynchronous to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none

module down_counter_sync (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire down_counter_pkg::pins_type pins_i,
  output down_counter_pkg::pins_type pins_o
);
  import down_counter_pkg::*;

  sync_state_type st_ff;
  sync_state_type nxt_st;

  // ==========================================================
  // Stage chain; stage1 feeds only stage2
  // ==========================================================
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage1 = pins_i;
    nxt_st.stage2 = st_ff.stage1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_ff <= '{stage1: PINS_IDLE, stage2: PINS_IDLE};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins_o = st_ff.stage2;

endmodule
`default_nettype wire

// ===== testbench/cascade_stage_model.sv
// Behavioural next counter stage fed by the block's terminal count.
// Assumes it shares the count clock pin with the block (synchronous cascade).
`timescale 1ns/1ps
`default_nettype none

module cascade_stage_model (
  input wire logic reset_i,
  input wire logic count_clock_i,
  input wire logic count_enable_n_i,
  output logic [7:0] stage_count_o
);
  import down_counter_pkg::*;

  // ==========================================================
  // Stage counter
  // ==========================================================
  // Steps only while prior stage signals terminal
  always_ff @(posedge count_clock_i or posedge reset_i) begin
    if (reset_i) begin
      stage_count_o <= COUNT_MAX;
    end else if (!count_enable_n_i) begin
      stage_count_o <= stage_count_o - 8'h01;
    end
  end
endmodule

`default_nettype wire

// ===== testbench/presettable_down_counter_8bit_tb.sv
// Self-checking bench for the down counter, its status bus and a cascade.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  $display("MISMATCH %s expected %h seen %h", n, e, g); errors++; end end

module presettable_down_counter_8bit_tb;
  import down_counter_pkg::*;
  typedef struct packed {
    logic clr_n; logic asy_n; logic syn_n; logic en_n;
    logic [7:0] pre; logic [7:0] cnt; logic tc_n;
  } row_type;
  logic clk_sys = 1'b0;
  logic reset = 1'b0;
  logic count_clock = 1'b0, clear_n = 1'b1, async_n = 1'b1, sync_n = 1'b1, en_n = 1'b1;
  logic [7:0] preset = 8'h00;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0, wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h1;
  logic tc_n, wait_req, irq;
  logic [31:0] rdata, q;
  logic [7:0] stage;
  int errors = 0;
  int check_count = 0;
  row_type rows [10] = '{
    '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'hfe, 1'b1},
    '{1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 8'hfe, 1'b1},
    '{1'b1, 1'b1, 1'b0, 1'b1, 8'ha5, 8'ha5, 1'b1},
    '{1'b1, 1'b1, 1'b0, 1'b0, 8'h01, 8'h01, 1'b1},
    '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00, 1'b0},
    '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'hff, 1'b1},
    '{1'b1, 1'b0, 1'b0, 1'b0, 8'h3c, 8'h3c, 1'b1},
    '{1'b0, 1'b0, 1'b0, 1'b0, 8'h3c, 8'hff, 1'b1},
    '{1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0},
    '{1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 1'b1}};

  always #2 clk_sys = ~clk_sys;

  down_counter dut_u (.clk_sys_i(clk_sys), .reset_i(reset), .count_clock_i(count_clock),
    .clear_to_max_n_i(clear_n), .async_load_n_i(async_n), .sync_load_n_i(sync_n),
    .count_enable_n_i(en_n), .preset_word_i(preset), .terminal_count_n_o(tc_n),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
    .irq_o(irq));

  cascade_stage_model partner_u (.reset_i(reset), .count_clock_i(count_clock),
    .count_enable_n_i(tc_n), .stage_count_o(stage));

  // ==========================================================
  // Tasks, entered just after a rising edge
  // ==========================================================
  task automatic stop_test();
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Holds the request until waitrequest is sampled low; the watchdog ends a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk_sys);
    end while (wait_req !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic pulse();
    count_clock <= 1'b1;
    repeat (4) @(posedge clk_sys);
    count_clock <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    // Rising reset edge also clears the cascade model
    reset <= 1'b1;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      {clear_n, async_n, sync_n, en_n, preset} <=
        {rows[i].clr_n, rows[i].asy_n, rows[i].syn_n, rows[i].en_n, rows[i].pre};
      repeat (4) @(posedge clk_sys);
      pulse();
      bus(1'b0, OFS_COUNT, 32'h0, q);
      `CHK("count", rows[i].cnt, q[7:0])
      `CHK("terminal", rows[i].tc_n, tc_n)
    end
    `CHK("cascade stage", 8'hfe, stage)
    async_n <= 1'b0;
    preset <= 8'h5a;
    repeat (5) @(posedge clk_sys);
    bus(1'b0, OFS_COUNT, 32'h0, q);
    `CHK("async load", 8'h5a, q[7:0])
    async_n <= 1'b1;
    @(posedge clk_sys);
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, OFS_MASK, 32'h10, q);
    `CHK("irq raised", 1'b1, irq)
    bus(1'b0, OFS_STATUS, 32'h0, q);
    `CHK("clear event", 1'b1, q[EVT_CLEAR])
    `CHK("status events", 5'h1f, q[4:0])
    `CHK("irq cleared", 1'b0, irq)
    bus(1'b0, OFS_STATUS, 32'h0, q);
    `CHK("status after read", 32'h0, q)
    // Mask write without byte lane 0 is ignored
    be <= 4'h0;
    bus(1'b1, OFS_MASK, 32'h1f, q);
    be <= 4'h1;
    bus(1'b0, OFS_MASK, 32'h0, q);
    `CHK("mask byte enable", 32'h10, q)
    // Synced pin levels: clock 0, controls high, preset 5a
    bus(1'b0, OFS_PINS, 32'h0, q);
    `CHK("pin levels", 32'h0000_0f5a, q)
    bus(1'b0, 4'h2, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    reset <= 1'b1;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    bus(1'b0, OFS_COUNT, 32'h0, q);
    `CHK("reset count", COUNT_MAX, q[7:0])
    `CHK("reset terminal", 1'b1, tc_n)
    `CHK("reset irq", 1'b0, irq)
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    stop_test();
  end
endmodule

`default_nettype wire
